// ===== shared/pwt_pkg.sv
`default_nettype none
package pwt_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_CTRL  = 12'h02f2;
    localparam logic [11:0] IDX_TRIM  = 12'h02f3;
    localparam logic [11:0] IDX_RATEH = 12'h02f4;
    localparam logic [11:0] IDX_RATEL = 12'h02f5;
    localparam logic [11:0] IDX_RSVD  = 12'h02f6;
    localparam logic [11:0] IDX_STAT  = 12'h0300;
    localparam logic [11:0] IDX_MASK  = 12'h0301;
    localparam logic [11:0] ADDR_CTRL  = {IDX_CTRL[9:0], 2'b00};
    localparam logic [11:0] ADDR_TRIM  = {IDX_TRIM[9:0], 2'b00};
    localparam logic [11:0] ADDR_RATEH = {IDX_RATEH[9:0], 2'b00};
    localparam logic [11:0] ADDR_RATEL = {IDX_RATEL[9:0], 2'b00};
    localparam logic [11:0] ADDR_RSVD  = {IDX_RSVD[9:0], 2'b00};
    localparam logic [11:0] ADDR_STAT  = {IDX_STAT[9:0], 2'b00};
    localparam logic [11:0] ADDR_MASK  = {IDX_MASK[9:0], 2'b00};
    // control field positions
    localparam int CTL_TBSEL = 7;
    localparam int CTL_WAVE  = 4;
    localparam int CTL_PINOE = 3;
    localparam int CTL_FE    = 2;
    localparam int CTL_IE    = 1;
    localparam int CTL_FLAG  = 0;
    localparam int TRIM_LSB  = 2;
    localparam int TRIM_W    = 6;
    localparam int RATE_W    = 16;
    // reset values
    localparam logic [7:0]  CTRL_RST = 8'h00;
    localparam logic [5:0]  TRIM_RST = 6'h00;
    localparam logic [15:0] RATE_RST = 16'h0000;
    // timing
    localparam int CLK_PERIOD_NS    = 20;
    localparam int OSC_TICK_NS      = 100000;
    localparam int OSC_TICK_CYCLES  = OSC_TICK_NS / CLK_PERIOD_NS;
    localparam int TRIM_STEP_CYCLES = 16;
    localparam int TRIM_TOP_WEIGHT  = 32;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pwt_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pwt_apb_rsp_t;

    typedef struct packed {
        logic         tbsel;
        logic         wave_sel;
        logic         pin_oe;
        logic         fe;
        logic         irq_en;
        logic         flag;
        logic [5:0]   trim;
        logic [15:0]  rate;
        logic [15:0]  presc;
        logic [16:0]  per_cnt;
        logic         toggle;
        logic         pulse;
        logic         pin;
        logic         irq;
        pwt_apb_rsp_t rsp;
    } pwt_state_t;
endpackage
`default_nettype wire

// ===== rtl/pwt_periodic_timer.sv
// Summary of operation
// - control bit 7 picks time base: 0 internal oscillator, 1 bus clock.
// - time base bit not writable while enabled or enabled by same write.
// - bit 4 picks pin clock of twice period, else end-of-period pulse.
// - pin shows waveform only when pin enable bit 3 and enable set.
// - enable bit 2 starts the periodic timer; clearing it stops it.
// - interrupt requested while timeout flag and enable bit 1 both set.
// - timeout flag bit 0 sets each time the period elapses.
// - flag clears only on writing one; writing zero leaves it.
// - software clear beats a same-cycle timeout; flag stays clear.
// - trim bits 7..2; top bit lengthens, lower bits shorten less.
// - trim field resets to zero or a factory preset.
// - 16-bit rate in high/low bytes, writable only while disabled.
// - oscillator period is 2*(rate+1) ticks of 0.1 ms.
// - bus clock period is 2*(rate+1) bus clock cycles.
// - after a timeout the timer restarts on its own.
// - with bus clock selected a stopped clock freezes the count.
`timescale 1ns/1ns
`default_nettype none
module pwt_periodic_timer #(
    parameter int unsigned OSC_TICK_CYCLES  = pwt_pkg::OSC_TICK_CYCLES,
    parameter int unsigned TRIM_STEP_CYCLES = pwt_pkg::TRIM_STEP_CYCLES,
    parameter logic [5:0]  FACTORY_TRIM     = pwt_pkg::TRIM_RST
) (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire pwt_pkg::pwt_apb_req_t apb_req,
    output var pwt_pkg::pwt_apb_rsp_t  apb_rsp,
    output var logic                   wake_pin,
    output var logic                   irq
);
    pwt_pkg::pwt_state_t s;
    pwt_pkg::pwt_state_t next_s;

    logic [15:0] tick_len;
    logic [15:0] trim_up;
    logic [15:0] trim_dn;
    logic        tick;
    logic        timeout;
    logic        wr_go;
    logic        hit;
    logic [31:0] rd_data;

    // trim weights: top bit adds 32 steps, lower bits remove 16..1
    assign trim_up = s.trim[5] ?
        16'(TRIM_STEP_CYCLES * pwt_pkg::TRIM_TOP_WEIGHT) : 16'h0000;
    assign trim_dn = 16'(TRIM_STEP_CYCLES) * 16'(s.trim[4:0]);
    assign tick_len = 16'(OSC_TICK_CYCLES) + trim_up - trim_dn;

    // bus mode ticks every edge; a stopped clock simply freezes it
    assign tick = s.fe & (s.tbsel |
                  (s.presc == tick_len - 16'h0001));
    // two ticks per rate step: count 0 .. 2*rate+1
    assign timeout = tick & (s.per_cnt == {s.rate, 1'b1});

    // write takes effect at the edge where the master sees pready
    assign wr_go = apb_req.psel & apb_req.penable &
                   apb_req.pwrite & s.rsp.pready;

    always_comb begin
        hit = 1'b1;
        rd_data = 32'h0000_0000;
        unique case (apb_req.paddr)
            pwt_pkg::ADDR_CTRL:
                rd_data = 32'({s.tbsel, 2'b00, s.wave_sel, s.pin_oe,
                               s.fe, s.irq_en, s.flag});
            pwt_pkg::ADDR_TRIM:
                rd_data = 32'({s.trim, 2'b00});
            pwt_pkg::ADDR_RATEH:
                rd_data = 32'(s.rate[15:8]);
            pwt_pkg::ADDR_RATEL:
                rd_data = 32'(s.rate[7:0]);
            pwt_pkg::ADDR_RSVD:
                rd_data = 32'h0000_0000;
            pwt_pkg::ADDR_STAT:
                rd_data = 32'(s.flag);
            pwt_pkg::ADDR_MASK:
                rd_data = 32'(s.irq_en);
            default:
                hit = 1'b0;
        endcase
    end

    always_comb begin
        next_s = s;
        // period counting
        if (!s.fe) begin
            next_s.presc = 16'h0000;
            next_s.per_cnt = 17'h0_0000;
            next_s.toggle = 1'b0;
            next_s.pulse = 1'b0;
        end else begin
            if (s.tbsel || tick) begin
                next_s.presc = 16'h0000;
            end else begin
                next_s.presc = s.presc + 16'h0001;
            end
            if (timeout) begin
                next_s.per_cnt = 17'h0_0000;
            end else if (tick) begin
                next_s.per_cnt = s.per_cnt + 17'h0_0001;
            end
            if (timeout) begin
                next_s.flag = 1'b1;
                next_s.toggle = ~s.toggle;
                next_s.pulse = 1'b1;
            end else if (tick) begin
                // pulse lasts one tick, half the shortest period
                next_s.pulse = 1'b0;
            end
        end

        // apb: one wait state so read data comes from a flop
        next_s.rsp.pready = apb_req.psel & apb_req.penable &
                            ~s.rsp.pready;
        next_s.rsp.pslverr = 1'b0;
        next_s.rsp.prdata = 32'h0000_0000;
        if (next_s.rsp.pready) begin
            next_s.rsp.pslverr = ~hit;
            if (hit && !apb_req.pwrite) begin
                next_s.rsp.prdata = rd_data;
            end
        end

        // writes come after the timeout set so a clear wins
        if (wr_go) begin
            unique case (apb_req.paddr)
                pwt_pkg::ADDR_CTRL: begin
                    next_s.wave_sel = apb_req.pwdata[pwt_pkg::CTL_WAVE];
                    next_s.pin_oe = apb_req.pwdata[pwt_pkg::CTL_PINOE];
                    next_s.fe = apb_req.pwdata[pwt_pkg::CTL_FE];
                    next_s.irq_en = apb_req.pwdata[pwt_pkg::CTL_IE];
                    if (!s.fe && !apb_req.pwdata[pwt_pkg::CTL_FE]) begin
                        next_s.tbsel =
                            apb_req.pwdata[pwt_pkg::CTL_TBSEL];
                    end
                    if (apb_req.pwdata[pwt_pkg::CTL_FLAG]) begin
                        next_s.flag = 1'b0;
                    end
                end
                pwt_pkg::ADDR_STAT: begin
                    if (apb_req.pwdata[0]) begin
                        next_s.flag = 1'b0;
                    end
                end
                pwt_pkg::ADDR_MASK: begin
                    next_s.irq_en = apb_req.pwdata[0];
                end
                pwt_pkg::ADDR_TRIM: begin
                    next_s.trim = apb_req.pwdata[7:2];
                end
                pwt_pkg::ADDR_RATEH: begin
                    if (!s.fe) begin
                        next_s.rate[15:8] = apb_req.pwdata[7:0];
                    end
                end
                pwt_pkg::ADDR_RATEL: begin
                    if (!s.fe) begin
                        next_s.rate[7:0] = apb_req.pwdata[7:0];
                    end
                end
                default: begin
                end
            endcase
        end

        next_s.pin = next_s.fe & next_s.pin_oe &
            (next_s.wave_sel ? next_s.toggle : next_s.pulse);
        next_s.irq = next_s.flag & next_s.irq_en;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.tbsel <= pwt_pkg::CTRL_RST[pwt_pkg::CTL_TBSEL];
            s.wave_sel <= pwt_pkg::CTRL_RST[pwt_pkg::CTL_WAVE];
            s.pin_oe <= pwt_pkg::CTRL_RST[pwt_pkg::CTL_PINOE];
            s.fe <= pwt_pkg::CTRL_RST[pwt_pkg::CTL_FE];
            s.irq_en <= pwt_pkg::CTRL_RST[pwt_pkg::CTL_IE];
            s.flag <= pwt_pkg::CTRL_RST[pwt_pkg::CTL_FLAG];
            s.trim <= FACTORY_TRIM;
            s.rate <= pwt_pkg::RATE_RST;
        end else begin
            s <= next_s;
        end
    end

    assign apb_rsp = s.rsp;
    assign wake_pin = s.pin;
    assign irq = s.irq;

    logic ctrl_wr;
    logic stat_wr;
    logic trim_wr;
    logic mask_wr;
    logic rateh_wr;
    logic ratel_wr;

    // decoded write strobes for the checks below
    assign ctrl_wr  = wr_go & (apb_req.paddr == pwt_pkg::ADDR_CTRL);
    assign stat_wr  = wr_go & (apb_req.paddr == pwt_pkg::ADDR_STAT);
    assign trim_wr  = wr_go & (apb_req.paddr == pwt_pkg::ADDR_TRIM);
    assign mask_wr  = wr_go & (apb_req.paddr == pwt_pkg::ADDR_MASK);
    assign rateh_wr = wr_go & (apb_req.paddr == pwt_pkg::ADDR_RATEH);
    assign ratel_wr = wr_go & (apb_req.paddr == pwt_pkg::ADDR_RATEL);

    irq_level_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irq == (s.flag && s.irq_en))
        else $error("irq does not follow flag and enable");

    irq_hold_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (irq && !wr_go) |=> irq)
        else $error("irq dropped without a register write");

    tbsel_lock_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.fe || (wr_go && apb_req.pwdata[pwt_pkg::CTL_FE]))
        |=> $stable(s.tbsel))
        else $error("time base changed while enabled");

    rate_lock_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s.fe |=> $stable(s.rate))
        else $error("rate changed while enabled");

    flag_clear_wins_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (wr_go && apb_req.paddr == pwt_pkg::ADDR_STAT &&
         apb_req.pwdata[0]) |=> !s.flag)
        else $error("flag not cleared by write of one");

    flag_sticky_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.flag && !wr_go) |=> s.flag)
        else $error("flag cleared without a write");

    flag_set_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (timeout && !wr_go) |=> s.flag ##0 s.per_cnt == 17'h0_0000)
        else $error("timeout did not set flag and restart");

    held_idle_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !$past(s.fe) |-> (s.per_cnt == 17'h0_0000 &&
                          s.presc == 16'h0000))
        else $error("counter not held while disabled");

    pin_gate_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wake_pin |-> (s.fe && s.pin_oe))
        else $error("pin active while gated off");

    clock_wave_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (timeout && s.fe) |=> (s.toggle != $past(s.toggle)))
        else $error("pin clock did not toggle at timeout");

    pulse_cause_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(s.pulse) |-> $past(timeout))
        else $error("pulse without a timeout");

    bus_period_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.fe && s.tbsel && s.rate == 16'h0000 &&
         s.per_cnt == 17'h0_0000 && !wr_go) |-> ##1 timeout)
        else $error("bus mode rate zero not two cycles");

    osc_freeze_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.fe && !s.tbsel && !tick) |=> $stable(s.per_cnt))
        else $error("count moved between oscillator ticks");

    tbsel_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (ctrl_wr && !s.fe && !apb_req.pwdata[pwt_pkg::CTL_FE])
        |=> s.tbsel == $past(apb_req.pwdata[pwt_pkg::CTL_TBSEL]))
        else $error("time base bit not taken while disabled");

    wave_clock_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.fe && s.pin_oe && s.wave_sel && !wr_go)
        |=> wake_pin == s.toggle)
        else $error("pin does not show the clock waveform");

    wave_pulse_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.fe && s.pin_oe && !s.wave_sel && !wr_go)
        |=> wake_pin == s.pulse)
        else $error("pin does not show the pulse waveform");

    pulse_end_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.pulse && tick && !timeout)
        |=> !s.pulse)
        else $error("pulse longer than one tick");

    pin_oe_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ctrl_wr
        |=> s.pin_oe == $past(apb_req.pwdata[pwt_pkg::CTL_PINOE]))
        else $error("pin enable bit not written");

    fe_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ctrl_wr
        |=> s.fe == $past(apb_req.pwdata[pwt_pkg::CTL_FE]))
        else $error("enable bit not written");

    count_step_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (tick && !timeout)
        |=> s.per_cnt == $past(s.per_cnt) + 17'h0_0001)
        else $error("period count did not advance on a tick");

    irq_mask_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mask_wr
        |=> s.irq_en == $past(apb_req.pwdata[0]))
        else $error("interrupt enable alias not written");

    ctrl_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (ctrl_wr && s.flag && !apb_req.pwdata[pwt_pkg::CTL_FLAG])
        |=> s.flag)
        else $error("flag cleared by writing zero");

    stat_keep_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (stat_wr && s.flag && !apb_req.pwdata[0])
        |=> s.flag)
        else $error("status flag cleared by writing zero");

    ctrl_clear_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (ctrl_wr && apb_req.pwdata[pwt_pkg::CTL_FLAG])
        |=> !s.flag)
        else $error("flag not cleared through control");

    trim_write_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        trim_wr
        |=> s.trim == $past(apb_req.pwdata[7:2]))
        else $error("trim field not written");

    trim_up_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        s.trim[5]
        |-> tick_len >= 16'(OSC_TICK_CYCLES))
        else $error("top trim bit shortened the tick");

    rate_low_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (ratel_wr && !s.fe)
        |=> s.rate[7:0] == $past(apb_req.pwdata[7:0]))
        else $error("rate low byte not written");

    rate_high_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (rateh_wr && !s.fe)
        |=> s.rate[15:8] == $past(apb_req.pwdata[7:0]))
        else $error("rate high byte not written");

    presc_step_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        (s.fe && !s.tbsel && !tick)
        |=> s.presc == $past(s.presc) + 16'h0001)
        else $error("oscillator prescaler did not advance");

    count_restart_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        timeout
        |=> (s.per_cnt == 17'h0_0000 && s.presc == 16'h0000))
        else $error("timer did not restart after timeout");

    enable_start_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $rose(s.fe)
        |-> (s.per_cnt == 17'h0_0000 && s.presc == 16'h0000))
        else $error("enable did not begin a full period");
endmodule
`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int TICK = 4;
    logic                  clk_sys = 1'b0;
    logic                  rst_n   = 1'b0;
    pwt_pkg::pwt_apb_req_t apb_req = '0;
    pwt_pkg::pwt_apb_rsp_t apb_rsp;
    logic                  wake_pin;
    logic                  irq;
    int                    fail_count = 0;
    int                    num_checks = 0;
    logic [15:0]           rate;
    logic [5:0]            trim;
    logic [7:0]            c;
    logic [31:0]           q;
    logic                  e;
    int                    n;
    int                    x;

    always #10 clk_sys = ~clk_sys;

    pwt_periodic_timer #(
        .OSC_TICK_CYCLES (TICK),
        .TRIM_STEP_CYCLES(1),
        .FACTORY_TRIM    (6'h00)
    ) dut (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .apb_req (apb_req),
        .apb_rsp (apb_rsp),
        .wake_pin(wake_pin),
        .irq     (irq)
    );

    task automatic test_done();
        if (fail_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // one idle cycle after each transfer keeps psel from two drives at once
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int i;
        apb_req.psel <= 1'b1;
        apb_req.pwrite <= wr;
        apb_req.paddr <= a;
        apb_req.pwdata <= d;
        @(posedge clk_sys);
        apb_req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
            if (i > 20) begin
                fail_count++;
                test_done();
            end
        end while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(q, {24'h00_0000, exp});
    endtask

    task automatic wait_rise(output int cnt);
        logic prev;
        cnt = 0;
        prev = 1'b1;
        forever begin
            @(posedge clk_sys);
            cnt++;
            if (prev === 1'b0 && wake_pin === 1'b1) break;
            prev = wake_pin;
            if (cnt > 3000) begin
                fail_count++;
                test_done();
            end
        end
    endtask

    function automatic int exp_per(input logic tb, input logic [15:0] r,
                                   input logic [5:0] t);
        int tk;
        tk = tb ? 1 : TICK + 32 * int'(t[5]) - int'(t[4:0]);
        return 2 * (int'(r) + 1) * tk;
    endfunction

    initial begin
        void'($urandom(32'h4d92));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rchk(pwt_pkg::ADDR_CTRL, 8'h00);
        rchk(pwt_pkg::ADDR_TRIM, 8'h00);
        rchk(pwt_pkg::ADDR_RATEL, 8'h00);
        rchk(pwt_pkg::ADDR_RSVD, 8'h00);
        apb(1'b0, 12'h010, 32'h0000_0000);
        check(32'(e), 32'h0000_0001);
        c = 8'($urandom);
        apb(1'b1, pwt_pkg::ADDR_TRIM, {24'h00_0000, c});
        rchk(pwt_pkg::ADDR_TRIM, c & 8'hfc);
        apb(1'b1, pwt_pkg::ADDR_CTRL, 32'h0000_0084);
        rchk(pwt_pkg::ADDR_CTRL, 8'h04);
        apb(1'b1, pwt_pkg::ADDR_RATEL, 32'h0000_0055);
        rchk(pwt_pkg::ADDR_RATEL, 8'h00);
        apb(1'b1, pwt_pkg::ADDR_CTRL, 32'h0000_0000);
        for (int k = 0; k < 8; k++) begin
            trim = (k[1:0] == 2'd1) ? 6'h21 : (k[1:0] == 2'd2) ? 6'h03 : 6'h00;
            rate = 16'($urandom % 8);
            c = {k[2], 2'b00, k[0], 4'b1110};
            apb(1'b1, pwt_pkg::ADDR_CTRL, {24'h00_0000, c & 8'hf9});
            apb(1'b1, pwt_pkg::ADDR_TRIM, {24'h00_0000, trim, 2'b00});
            apb(1'b1, pwt_pkg::ADDR_RATEH, 32'h0000_0000);
            apb(1'b1, pwt_pkg::ADDR_RATEL, {16'h0000, rate});
            rchk(pwt_pkg::ADDR_RATEL, rate[7:0]);
            apb(1'b1, pwt_pkg::ADDR_CTRL, {24'h00_0000, c});
            wait_rise(n);
            wait_rise(n);
            x = exp_per(k[2], rate, trim) * (k[0] ? 2 : 1);
            check(n, x);
            @(posedge clk_sys);
            if (k[2] && !k[0]) check(32'(wake_pin), 32'h0000_0000);
            @(posedge clk_sys);
            check(32'(irq), 32'h0000_0001);
            apb(1'b1, pwt_pkg::ADDR_CTRL, {24'h00_0000, c & 8'hf8});
            @(posedge clk_sys);
            check(32'(wake_pin), 32'h0000_0000);
            rchk(pwt_pkg::ADDR_CTRL, (c & 8'hf8) | 8'h01);
            apb(1'b1, pwt_pkg::ADDR_CTRL, {24'h00_0000, c & 8'hf8});
            @(posedge clk_sys);
            check(32'(irq), 32'h0000_0000);
            apb(1'b1, pwt_pkg::ADDR_MASK, 32'h0000_0001);
            @(posedge clk_sys);
            check(32'(irq), 32'h0000_0001);
            apb(1'b1, pwt_pkg::ADDR_STAT, 32'h0000_0001);
            @(posedge clk_sys);
            check(32'(irq), 32'h0000_0000);
            rchk(pwt_pkg::ADDR_STAT, 8'h00);
        end
        apb(1'b1, pwt_pkg::ADDR_CTRL, 32'h0000_0006);
        n = 0;
        repeat (40) begin
            @(posedge clk_sys);
            n = n + int'(wake_pin === 1'b1);
        end
        check(n, 0);
        check(32'(irq), 32'h0000_0001);
        // rate zero in bus mode: one of two clears meets a timeout
        apb(1'b1, pwt_pkg::ADDR_CTRL, 32'h0000_0000);
        apb(1'b1, pwt_pkg::ADDR_RATEL, 32'h0000_0000);
        apb(1'b1, pwt_pkg::ADDR_CTRL, 32'h0000_0006);
        repeat (2) begin
            @(posedge clk_sys);
            apb(1'b1, pwt_pkg::ADDR_STAT, 32'h0000_0001);
            check(32'(irq), 32'h0000_0000);
        end
        test_done();
    end
endmodule
`default_nettype wire
